// ==== common/supply_reset_map.vh ====
`ifndef SUPPLY_RESET_MAP_VH
`define SUPPLY_RESET_MAP_VH
// ---------------------------------------------------------------
// clock and timing figures
// ---------------------------------------------------------------
// clock period in ns
`define CLK_PERIOD_NS 40
// power-up reset timeout, nominal, in ms
`define POWER_UP_RESET_TIMEOUT_MS 200
// power-up timeout cycles: 200 ms / 40 ns
`define POWER_UP_RESET_TIMEOUT_CYC \
  ((`POWER_UP_RESET_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
// watchdog period, nominal, in ms (1.6 s)
`define WATCHDOG_PERIOD_MS 1600
// watchdog cycles: 1.6 s / 40 ns
`define WATCHDOG_PERIOD_CYC ((`WATCHDOG_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)
// supply glitch reject width in ns
`define SUPPLY_GLITCH_REJECT_WIDTH_NS 100
// glitch filter cycles, rounded up
`define SUPPLY_GLITCH_REJECT_CYC \
  ((`SUPPLY_GLITCH_REJECT_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// threshold to reset delay limit in ns
`define THRESHOLD_TO_RESET_DELAY_NS 5000
// debounce time for a manual pushbutton in ms
`define MANUAL_DEBOUNCE_MS 10
// debounce cycles
`define MANUAL_DEBOUNCE_CYC ((`MANUAL_DEBOUNCE_MS * 1000000) / `CLK_PERIOD_NS)
`endif

// ==== hdl/edge_filter.v ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// two-flop synchroniser plus stability filter
// ---------------------------------------------------------------
module edge_filter #(
  parameter integer STABLE_CYC = 3,
  parameter integer CNT_W = 20,
  parameter [0:0] INIT = 1'b0
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire din,
  output reg dout_reg
);
  reg sync1_reg; // first flop, read only by sync2
  reg sync2_reg; // second flop
  reg [CNT_W-1:0] cnt_reg; // cycles the new level has held

  // synchronise, then accept a level only once it held long enough
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= INIT;
      sync2_reg <= INIT;
      cnt_reg <= {CNT_W{1'b0}};
      dout_reg <= INIT;
    end else if (ce) begin
      sync1_reg <= din;
      sync2_reg <= sync1_reg;
      if (sync2_reg == dout_reg) begin
        cnt_reg <= {CNT_W{1'b0}}; // no pending change
      end else if (cnt_reg >= STABLE_CYC[CNT_W-1:0] - 1'b1) begin
        dout_reg <= sync2_reg; // change confirmed
        cnt_reg <= {CNT_W{1'b0}};
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/supply_reset_watchdog.v ====
`timescale 1ns/1ps
`default_nettype none
`include "supply_reset_map.vh"
// Summary of operation
// - watchdog expires after 1.6 s without activity
// - watchdog expiry runs normal reset sequence
// - any data edge clears watchdog counter
// - watchdog held cleared during any reset
// - parameter removes the watchdog entirely
// - hold reset 200 ms after supply ok
// - release both outputs after timeout
// - assert reset while supply below threshold
// - assert reset within 5 us of crossing
// - ignore supply dips sampled on fewer than 3 clock edges
// - outputs open drain, drive asserted level only
// - external forced level does not hold reset, starts at most one
// - rising edge on high pin starts timeout, only while released
// - falling edge on low pin starts timeout, only while released
// - debounce manual pushbutton into one reset
module supply_reset_watchdog #(
  parameter HAS_WATCHDOG = 1,
  parameter integer TIMEOUT_CYC = `POWER_UP_RESET_TIMEOUT_CYC,
  parameter integer WATCHDOG_CYC = `WATCHDOG_PERIOD_CYC,
  parameter integer DEBOUNCE_CYC = `MANUAL_DEBOUNCE_CYC
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire supply_ok,
  input wire data_line_in,
  input wire reset_hi_in,
  output wire reset_hi_out,
  output wire reset_hi_oe,
  input wire reset_n_in,
  output wire reset_n_out,
  output wire reset_n_oe,
  output wire reset_active
);
  // ---------------------------------------------------------------
  // constants and states
  // ---------------------------------------------------------------
  localparam [1:0] ST_LOW_SUPPLY = 2'b00; // supply under threshold
  localparam [1:0] ST_TIMEOUT = 2'b01; // timing the reset hold
  localparam [1:0] ST_RUN = 2'b10; // outputs released
  localparam integer GLITCH_CYC = `SUPPLY_GLITCH_REJECT_CYC;
  localparam integer TIMEOUT_LAST = TIMEOUT_CYC - 1; // last timeout count
  localparam integer WATCHDOG_LAST = WATCHDOG_CYC - 1; // last idle count
  // counters are 28 bits wide: cut the 32-bit figures on purpose
  localparam [27:0] TIMEOUT_END = TIMEOUT_LAST[27:0];
  localparam [27:0] WATCHDOG_END = WATCHDOG_LAST[27:0];

  // ---------------------------------------------------------------
  // input conditioning
  // ---------------------------------------------------------------
  wire supply_ok_f; // filtered supply-ok
  wire data_f; // synchronised data line
  wire hi_f; // debounced active-high pin
  wire lo_f; // debounced active-low pin

  // supply dips seen on fewer than GLITCH_CYC clock edges never pass
  edge_filter #(.STABLE_CYC(GLITCH_CYC), .CNT_W(4), .INIT(1'b0))
    u_supply (.clk(clk), .rst(rst), .ce(ce), .din(supply_ok),
    .dout_reg(supply_ok_f));

  // data line: synchroniser only, one-cycle stability
  edge_filter #(.STABLE_CYC(1), .CNT_W(2), .INIT(1'b1))
    u_data (.clk(clk), .rst(rst), .ce(ce), .din(data_line_in),
    .dout_reg(data_f));

  // pushbutton debouncers on the pins
  edge_filter #(.STABLE_CYC(DEBOUNCE_CYC), .CNT_W(28), .INIT(1'b1))
    u_hi (.clk(clk), .rst(rst), .ce(ce), .din(reset_hi_in),
    .dout_reg(hi_f));
  edge_filter #(.STABLE_CYC(DEBOUNCE_CYC), .CNT_W(28), .INIT(1'b0))
    u_lo (.clk(clk), .rst(rst), .ce(ce), .din(reset_n_in),
    .dout_reg(lo_f));

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  reg data_prev_reg; // last data level
  reg hi_prev_reg; // last high-pin level
  reg lo_prev_reg; // last low-pin level
  reg [1:0] state_reg; // sequencer state
  reg [1:0] state_next;
  reg [27:0] tmo_reg; // timeout counter
  reg [27:0] tmo_next;
  reg [27:0] wdg_reg; // watchdog counter
  reg [27:0] wdg_next;

  wire driving = (state_reg != ST_RUN); // own drive active
  wire data_edge = (data_f != data_prev_reg);
  // edges only count while released, so own drive cannot retrigger
  // hazard: an edge seen while driving is dropped, not delayed
  wire hi_rise = hi_f & ~hi_prev_reg & ~driving;
  wire lo_fall = ~lo_f & lo_prev_reg & ~driving;
  wire wdg_expire = (HAS_WATCHDOG != 0) &&
    (wdg_reg >= WATCHDOG_END);

  // previous-level registers for the edge detectors
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      data_prev_reg <= 1'b1;
      hi_prev_reg <= 1'b1;
      lo_prev_reg <= 1'b0;
    end else if (ce) begin
      data_prev_reg <= data_f;
      hi_prev_reg <= hi_f;
      lo_prev_reg <= lo_f;
    end
  end

  // ---------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------
  // next state and timeout count
  always @* begin
    state_next = state_reg;
    tmo_next = tmo_reg;
    case (state_reg)
      ST_LOW_SUPPLY: begin
        tmo_next = 28'h0000000;
        if (supply_ok_f) begin
          state_next = ST_TIMEOUT;
        end
      end
      ST_TIMEOUT: begin
        if (tmo_reg >= TIMEOUT_END) begin
          state_next = ST_RUN;
          tmo_next = 28'h0000000;
        end else begin
          tmo_next = tmo_reg + 28'h0000001;
        end
      end
      ST_RUN: begin
        tmo_next = 28'h0000000;
        // manual edges and watchdog use the same sequence
        if (hi_rise || lo_fall || wdg_expire) begin
          state_next = ST_TIMEOUT;
        end
      end
      default: begin
        state_next = ST_LOW_SUPPLY;
      end
    endcase
    // supply loss overrides everything
    if (!supply_ok_f) begin
      state_next = ST_LOW_SUPPLY;
      tmo_next = 28'h0000000;
    end
  end

  // watchdog counter
  // restarts on expiry, so one lapse of activity gives one reset
  // and a quiet line keeps resetting the host once per watchdog period plus timeout
  always @* begin
    wdg_next = wdg_reg + 28'h0000001;
    if ((HAS_WATCHDOG == 0) || driving || data_edge || wdg_expire) begin
      wdg_next = 28'h0000000;
    end
  end

  // state registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_LOW_SUPPLY;
      tmo_reg <= 28'h0000000;
      wdg_reg <= 28'h0000000;
    end else if (ce) begin
      state_reg <= state_next;
      tmo_reg <= tmo_next;
      wdg_reg <= wdg_next;
    end
  end

  // ---------------------------------------------------------------
  // open-drain outputs
  // ---------------------------------------------------------------
  // enable follows the next state, so it moves with the state register
  reg drive_reg; // registered drive enable
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_reg <= 1'b1;
    end else if (ce) begin
      drive_reg <= (state_next != ST_RUN);
    end
  end

  // drive only the asserted level, release otherwise
  // the pulls on the board give the idle level of each pin
  assign reset_hi_out = 1'b1;
  assign reset_hi_oe = drive_reg;
  assign reset_n_out = 1'b0;
  assign reset_n_oe = drive_reg;
  assign reset_active = drive_reg;
endmodule
`default_nettype wire

// ==== testbench/reset_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module reset_monitor #(
  parameter integer TIMEOUT_CYC = 50,
  parameter integer WATCHDOG_CYC = 200,
  parameter integer HAS_WATCHDOG = 1
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire supply_ok,
  input wire data_line_in,
  input wire reset_hi_out,
  input wire reset_hi_oe,
  input wire reset_n_out,
  input wire reset_n_oe,
  input wire reset_active
);
  reg [15:0] ok_cnt; // cycles supply has stood ok
  reg [15:0] idle_cnt; // released cycles with no data edge
  reg data_q;
  // activity and supply counters
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ok_cnt <= 16'h0000;
      idle_cnt <= 16'h0000;
      data_q <= 1'b0;
    end else if (ce) begin
      data_q <= data_line_in;
      ok_cnt <= supply_ok ? ok_cnt + 16'h0001 : 16'h0000;
      idle_cnt <= (reset_hi_oe || data_q != data_line_in) ?
        16'h0000 : idle_cnt + 16'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_oe_pair: assert property (
    reset_hi_oe == reset_n_oe && reset_active == reset_hi_oe)
    else $error("reset enables disagree");
  a_drive_level: assert property (reset_hi_out && !reset_n_out)
    else $error("drive value not the asserted level");
  a_brownout_drive: assert property (
    !supply_ok [*4] |-> ##[0:125] reset_hi_oe)
    else $error("no reset after supply low");
  a_glitch_reject: assert property (
    !reset_hi_oe ##1 !supply_ok ##1 supply_ok |=> !reset_hi_oe [*6])
    else $error("short dip caused reset");
  a_timeout_min: assert property (
    $fell(reset_hi_oe) |-> ok_cnt > TIMEOUT_CYC)
    else $error("reset released early");
  a_wdog_bound: assert property (
    HAS_WATCHDOG == 0 || idle_cnt <= WATCHDOG_CYC + 10)
    else $error("watchdog did not expire");
  a_reset_held: assert property (
    $fell(rst) |-> reset_hi_oe [*4])
    else $error("reset not driven after release");
  a_ce_freeze: assert property (!ce |=> $stable(reset_hi_oe))
    else $error("state moved while disabled");
endmodule
`default_nettype wire

// ==== testbench/host_reset_net.sv ====
`timescale 1ns/1ps
`default_nettype none
// reset wires with pulls, pushbuttons and host data activity
module host_reset_net (
  input wire clk,
  input wire hi_oe,
  input wire hi_out,
  input wire n_oe,
  input wire n_out,
  input wire push_hi,
  input wire push_n,
  input wire toggle_en,
  output wire hi_wire,
  output wire n_wire,
  output reg data_line
);
  // pull-down on the high pin, pull-up on the low pin
  assign hi_wire = (hi_oe & hi_out) | push_hi;
  assign n_wire = ~((n_oe & ~n_out) | push_n);
  initial data_line = 1'b1;
  // a live host keeps the data line moving
  always @(posedge clk) begin
    if (toggle_en) begin
      data_line <= ~data_line;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam integer TO = 50;
  localparam integer WD = 200;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg ce = 1'b1;
  reg supply_ok = 1'b0;
  reg push_hi = 1'b0;
  reg push_n = 1'b0;
  reg toggle_en = 1'b1;
  wire hi_out, hi_oe, n_out, n_oe, act, hi_wire, n_wire, data_line;
  wire hi_out2, hi_oe2, n_out2, n_oe2, act2, hi_wire2, n_wire2, data_line2;
  integer mismatches = 0;
  integer checks_done = 0;
  integer cyc = 0;
  integer n;
  supply_reset_watchdog #(.TIMEOUT_CYC(TO), .WATCHDOG_CYC(WD),
    .DEBOUNCE_CYC(4)) i_supply_reset_watchdog (.clk(clk), .rst(rst),
    .ce(ce), .supply_ok(supply_ok), .data_line_in(data_line),
    .reset_hi_in(hi_wire), .reset_hi_out(hi_out), .reset_hi_oe(hi_oe),
    .reset_n_in(n_wire), .reset_n_out(n_out), .reset_n_oe(n_oe),
    .reset_active(act));
  host_reset_net i_host_reset_net (.clk(clk), .hi_oe(hi_oe),
    .hi_out(hi_out), .n_oe(n_oe), .n_out(n_out), .push_hi(push_hi),
    .push_n(push_n), .toggle_en(toggle_en), .hi_wire(hi_wire),
    .n_wire(n_wire), .data_line(data_line));
  // second unit built without the watchdog, never pressed
  supply_reset_watchdog #(.HAS_WATCHDOG(0), .TIMEOUT_CYC(TO),
    .WATCHDOG_CYC(WD), .DEBOUNCE_CYC(4)) i_supply_reset_watchdog_nowd (
    .clk(clk), .rst(rst), .ce(ce), .supply_ok(supply_ok),
    .data_line_in(data_line2), .reset_hi_in(hi_wire2),
    .reset_hi_out(hi_out2), .reset_hi_oe(hi_oe2),
    .reset_n_in(n_wire2), .reset_n_out(n_out2), .reset_n_oe(n_oe2),
    .reset_active(act2));
  host_reset_net i_host_reset_net_nowd (.clk(clk), .hi_oe(hi_oe2),
    .hi_out(hi_out2), .n_oe(n_oe2), .n_out(n_out2), .push_hi(1'b0),
    .push_n(1'b0), .toggle_en(toggle_en), .hi_wire(hi_wire2),
    .n_wire(n_wire2), .data_line(data_line2));
  initial begin
    forever #20 clk = ~clk;
  end
  task chk(input logic seen, input logic exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("Error at %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // count cycles until the enable reaches v
  task wait_oe(input logic v, input integer lim);
    n = 0;
    while (hi_oe !== v && n < lim) begin
      @(posedge clk) #2;
      n = n + 1;
    end
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches = mismatches + 1;
      summarize;
    end
  end
  task t_power_up;
    supply_ok = 1'b1;
    ce = 1'b0;
    repeat (5) @(posedge clk) #2;
    ce = 1'b1;
    wait_oe(1'b0, TO + 40);
    chk(n >= TO + 3 && n <= TO + 15, 1'b1);
    chk(hi_wire, 1'b0);
    chk(n_wire, 1'b1);
    $display("power-up test done");
  endtask
  task t_brownout;
    @(posedge clk) #2;
    supply_ok = 1'b0;
    @(posedge clk) #2;
    supply_ok = 1'b1;
    repeat (10) @(posedge clk) #2;
    chk(hi_oe, 1'b0);
    supply_ok = 1'b0;
    wait_oe(1'b1, 125);
    chk(!hi_wire === 1'b0 && n_wire === 1'b0 && n < 125, 1'b1);
    repeat (3 * TO) @(posedge clk) #2;
    chk(hi_oe, 1'b1);
    supply_ok = 1'b1;
    wait_oe(1'b0, TO + 40);
    $display("brownout test done");
  endtask
  task t_watchdog;
    repeat (2 * WD) @(posedge clk) #2;
    chk(hi_oe, 1'b0);
    toggle_en = 1'b0;
    wait_oe(1'b1, WD + 40);
    chk(n >= WD - 2 && n <= WD + 15, 1'b1);
    chk(n_oe, 1'b1);
    chk(hi_oe2, 1'b0);
    wait_oe(1'b0, TO + 40);
    repeat (WD - 20) @(posedge clk) #2;
    chk(hi_oe, 1'b0);
    chk(hi_oe2, 1'b0);
    toggle_en = 1'b1;
    $display("watchdog test done");
  endtask
  // bouncing press: pulses of 1, 5 and 9 cycles
  task t_manual(input logic which);
    integer k;
    for (k = 0; k < 3; k = k + 1) begin
      {push_hi, push_n} = which ? 2'b10 : 2'b01;
      repeat (k * 4 + 1) @(posedge clk) #2;
      {push_hi, push_n} = 2'b00;
      @(posedge clk) #2;
    end
    chk(hi_oe, 1'b1);
    wait_oe(1'b0, TO + 40);
    chk(n >= TO - 25 && n < TO + 40, 1'b1);
    repeat (2 * TO) @(posedge clk) #2;
    chk(hi_oe, 1'b0);
    $display("manual test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #2 rst = 1'b0;
    t_power_up;
    t_brownout;
    t_watchdog;
    t_manual(1'b1);
    t_manual(1'b0);
    summarize;
  end
endmodule
bind supply_reset_watchdog reset_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC),
  .WATCHDOG_CYC(WATCHDOG_CYC), .HAS_WATCHDOG(HAS_WATCHDOG))
  i_reset_monitor (.clk(clk), .rst(rst),
  .ce(ce), .supply_ok(supply_ok), .data_line_in(data_line_in),
  .reset_hi_out(reset_hi_out), .reset_hi_oe(reset_hi_oe),
  .reset_n_out(reset_n_out), .reset_n_oe(reset_n_oe),
  .reset_active(reset_active));
`default_nettype wire
